// ===== bscs_pkg.sv
// package of constants for boot select and code security
// Functional notes
// RULE1 - idle with control 03h: loader area, reset
// RULE2 - reboot strap also selects loader area
// RULE3 - control bit 7 returns to application, restarts
// RULE4 - idle with control 01h: stay, update loader
// RULE5 - setting registers hidden in programming mode
// RULE6 - security bits only clear; full erase restores
// RULE7 - identity registers fixed, never writable
// RULE8 - read lock zero refuses all flash access
// RULE9 - inhibit zero: external table reads stay external
// RULE10 - internal table reads always reach everything; code refuses them while read lock is zero
// RULE11 - inhibit one: table reads unrestricted; code still refuses them while read lock is zero
// RULE12 - pair reboot enabled: pins a,b low boot loader
// RULE13 - single reboot enabled: pin c low boots loader
// RULE14 - writer sets clock bit per 24MHz threshold
// RULE15 - writer programs both areas each procedure
// RULE16 - plain external reset starts application area
// RULE17 - security byte latched before pins sampled
package bscs_pkg;
    localparam logic [31:0] BSCS_OFF_CTRL      = 32'h0000_0000;
    localparam logic [31:0] BSCS_OFF_STATUS    = 32'h0000_0004;
    localparam logic [31:0] BSCS_OFF_SECURITY  = 32'h0000_0008;
    localparam logic [31:0] BSCS_OFF_SEC_PROG  = 32'h0000_000c;
    localparam logic [31:0] BSCS_OFF_ERASE     = 32'h0000_0010;
    localparam logic [31:0] BSCS_OFF_MAKER_ID  = 32'h0000_0014;
    localparam logic [31:0] BSCS_OFF_DEVICE_ID = 32'h0000_0018;
    localparam logic [31:0] BSCS_OFF_PROG_MODE = 32'h0000_001c;
    localparam logic [31:0] BSCS_OFF_ACCESS    = 32'h0000_0020;
    localparam logic [7:0]  BSCS_CTRL_LOADER   = 8'h03;
    localparam logic [7:0]  BSCS_CTRL_UPDATE   = 8'h01;
    localparam int          BSCS_SWRST_BIT     = 7;
    localparam logic [7:0]  BSCS_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  BSCS_SEC_RESET     = 8'hff;
    localparam int          BSCS_SEC_LOCK      = 0;
    localparam int          BSCS_SEC_INHIBIT   = 1;
    localparam int          BSCS_SEC_PAIR      = 4;
    localparam int          BSCS_SEC_SINGLE    = 5;
    localparam int          BSCS_SEC_HICLK     = 7;
    localparam logic [7:0]  BSCS_MAKER_ID      = 8'h5a; // arbitrary value
    localparam logic [7:0]  BSCS_DEVICE_ID     = 8'h3c; // arbitrary value
    localparam logic [31:0] BSCS_ERASE_KEY     = 32'h0000_00a5;
    localparam logic [1:0]  BSCS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  BSCS_HTRANS_SEQ    = 2'h3;
    localparam logic [1:0]  BSCS_RESTART_CYC   = 2'h3;
    typedef enum logic [1:0] {BSCS_RUN, BSCS_RESTART} bscs_state_t;
endpackage : bscs_pkg

// ===== bscs_access_gate.sv
// access filter for flash and code table reads
`timescale 1ns/1ps
module bscs_access_gate
    import bscs_pkg::*;
(
    // security state
    input  wire logic       i_read_lock_n,
    input  wire logic       i_table_read_inhibit_n,
    // request
    input  wire logic       i_flash_req,
    input  wire logic       i_table_req,
    input  wire logic       i_exec_external,
    input  wire logic       i_target_internal,
    // decision
    output logic            o_flash_grant,
    output logic            o_table_grant
);
    always_comb
    begin
        o_flash_grant = i_flash_req & i_read_lock_n; // RULE8
        if (!i_table_req)
            o_table_grant = 1'b0;
        else if (!i_exec_external)
            o_table_grant = 1'b1; // RULE10
        else if (i_table_read_inhibit_n)
            o_table_grant = 1'b1; // RULE11
        else
            o_table_grant = ~i_target_internal; // RULE9
    end
endmodule : bscs_access_gate

// ===== bscs_top.sv
// boot source selection and code security with ahb-lite registers
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module bscs_top
    import bscs_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // cpu status and code fetch requests
    input  wire logic        i_cpu_idle,
    input  wire logic        i_flash_req,
    input  wire logic        i_table_req,
    input  wire logic        i_exec_external,
    input  wire logic        i_target_internal,
    // reboot straps
    input  wire logic        i_reboot_pin_a,
    input  wire logic        i_reboot_pin_b,
    input  wire logic        i_reboot_pin_c,
    // nonvolatile security image
    input  wire logic [7:0]  i_nv_security,
    // outputs
    output logic             o_loader_flash_sel,
    output logic             o_cpu_reset,
    output logic             o_flash_update_en,
    output logic             o_flash_grant,
    output logic             o_table_grant,
    output logic             o_high_clock_select
);
    logic [7:0]  boot_control_reg_q;
    logic [7:0]  code_security_byte_q;
    logic        sec_loaded_q;
    logic        cold_q;
    logic        prog_mode_q;
    logic        loader_q;
    logic        update_q;
    logic        idle_q;
    logic [1:0]  restart_cnt_q;
    bscs_state_t state_q;
    logic        ph_valid_q;
    logic        ph_write_q;
    logic [31:0] ph_addr_q;
    logic        flash_grant_c;
    logic        table_grant_c;
    logic        strap_reboot;
    logic        idle_rise;
    logic        wr_ctrl;
    logic        wr_sec;
    logic        wr_erase;
    logic        wr_prog;
    logic        software_return_reset;

    function automatic logic bus_hit(input logic [31:0] addr, input logic [31:0] off);
        bus_hit = (addr[31:2] == off[31:2]);
    endfunction : bus_hit

    // address phase capture; slave is always zero wait state
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q  <= 32'h0000_0000;
        end
        else if (i_hready)
        begin
            ph_valid_q <= i_hsel & (i_htrans == BSCS_HTRANS_NONSEQ || i_htrans == BSCS_HTRANS_SEQ);
            ph_write_q <= i_hwrite;
            ph_addr_q  <= i_haddr;
        end
    end

    assign wr_ctrl  = ph_valid_q & ph_write_q & bus_hit(ph_addr_q, BSCS_OFF_CTRL);
    assign wr_sec   = ph_valid_q & ph_write_q & bus_hit(ph_addr_q, BSCS_OFF_SEC_PROG) & ~prog_mode_q;
    assign wr_erase = ph_valid_q & ph_write_q & bus_hit(ph_addr_q, BSCS_OFF_ERASE)
                      & (i_hwdata == BSCS_ERASE_KEY);
    assign wr_prog  = ph_valid_q & ph_write_q & bus_hit(ph_addr_q, BSCS_OFF_PROG_MODE);
    assign software_return_reset  = wr_ctrl & i_hwdata[BSCS_SWRST_BIT];
    // hardware strap decision uses the already latched security byte
    assign strap_reboot = (~code_security_byte_q[BSCS_SEC_PAIR] & ~i_reboot_pin_a & ~i_reboot_pin_b) // RULE12
                        | (~code_security_byte_q[BSCS_SEC_SINGLE] & ~i_reboot_pin_c); // RULE13
    assign idle_rise = i_cpu_idle & ~idle_q;

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_hreadyout <= 1'b1;
        else
            o_hreadyout <= 1'b1;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_hresp <= 1'b0;
        else
            o_hresp <= 1'b0;
    end

    // registered read data: a read is decoded at its address phase, so the data phase is answered with no wait state,
    // and reads return the register values as they stand at the address phase
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_hrdata <= 32'h0000_0000;
        else if (i_hready && i_hsel && !i_hwrite && i_htrans[1])
        begin
            if (bus_hit(i_haddr, BSCS_OFF_CTRL))
                o_hrdata <= {24'h00_0000, boot_control_reg_q};
            else if (bus_hit(i_haddr, BSCS_OFF_STATUS))
                o_hrdata <= {27'h000_0000, prog_mode_q, update_q, loader_q, sec_loaded_q, 1'b0};
            else if (bus_hit(i_haddr, BSCS_OFF_SECURITY))
                o_hrdata <= (prog_mode_q || !code_security_byte_q[BSCS_SEC_LOCK])
                            ? 32'h0000_0000 : {24'h00_0000, code_security_byte_q}; // RULE5 RULE8
            else if (bus_hit(i_haddr, BSCS_OFF_MAKER_ID))
                o_hrdata <= (prog_mode_q || !code_security_byte_q[BSCS_SEC_LOCK])
                            ? 32'h0000_0000 : {24'h00_0000, BSCS_MAKER_ID}; // RULE5 RULE7
            else if (bus_hit(i_haddr, BSCS_OFF_DEVICE_ID))
                o_hrdata <= (prog_mode_q || !code_security_byte_q[BSCS_SEC_LOCK])
                            ? 32'h0000_0000 : {24'h00_0000, BSCS_DEVICE_ID}; // RULE5 RULE7
            else if (bus_hit(i_haddr, BSCS_OFF_PROG_MODE))
                o_hrdata <= {31'h0000_0000, prog_mode_q};
            else if (bus_hit(i_haddr, BSCS_OFF_ACCESS))
                o_hrdata <= {30'h0000_0000, table_grant_c, flash_grant_c};
            else
                o_hrdata <= 32'h0000_0000;
        end
        else
            o_hrdata <= 32'h0000_0000;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            prog_mode_q <= 1'b0;
        else if (wr_prog)
            prog_mode_q <= i_hwdata[0];
    end

    // security byte: image copied once after reset release, then clear-only writes; the keyed erase restores ff
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            code_security_byte_q <= BSCS_SEC_RESET;
            sec_loaded_q         <= 1'b0;
        end
        else if (!sec_loaded_q)
        begin
            code_security_byte_q <= i_nv_security; // RULE17
            sec_loaded_q         <= 1'b1;
        end
        else if (wr_erase)
            code_security_byte_q <= BSCS_SEC_RESET; // RULE6
        else if (wr_sec && code_security_byte_q[BSCS_SEC_LOCK])
            code_security_byte_q <= code_security_byte_q & i_hwdata[7:0]; // RULE6
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            idle_q <= 1'b0;
        else
            idle_q <= i_cpu_idle;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            boot_control_reg_q <= BSCS_CTRL_RESET;
        else if (software_return_reset)
            boot_control_reg_q <= BSCS_CTRL_RESET; // RULE3
        else if (wr_ctrl)
            boot_control_reg_q <= {1'b0, i_hwdata[6:0]};
    end

    // boot source: strap applied while the cold restart still holds the cpu,
    // so the area is settled before the cpu leaves reset
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            loader_q <= 1'b0; // RULE16
        else if (!sec_loaded_q)
            loader_q <= 1'b0;
        else if (software_return_reset)
            loader_q <= 1'b0; // RULE3
        else if (idle_rise && boot_control_reg_q == BSCS_CTRL_LOADER)
            loader_q <= 1'b1; // RULE1
        else if (cold_q && state_q == BSCS_RESTART && strap_reboot)
            loader_q <= 1'b1; // RULE2
    end

    // straps only count on the restart after an external reset
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            cold_q <= 1'b1;
        else if (state_q == BSCS_RUN)
            cold_q <= 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            update_q <= 1'b0;
        else if (software_return_reset)
            update_q <= 1'b0;
        else if (idle_rise && boot_control_reg_q == BSCS_CTRL_UPDATE)
            update_q <= 1'b1; // RULE4
    end

    // restart sequencer holds cpu reset for a few cycles
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q       <= BSCS_RESTART;
            restart_cnt_q <= BSCS_RESTART_CYC;
        end
        else
        begin
            case (state_q)
                BSCS_RUN:
                begin
                    if (software_return_reset || (idle_rise && boot_control_reg_q == BSCS_CTRL_LOADER)) // RULE1 RULE3
                    begin
                        state_q       <= BSCS_RESTART;
                        restart_cnt_q <= BSCS_RESTART_CYC;
                    end
                end
                BSCS_RESTART:
                begin
                    if (restart_cnt_q == 2'h0 && sec_loaded_q)
                        state_q <= BSCS_RUN;
                    else if (restart_cnt_q != 2'h0)
                        restart_cnt_q <= restart_cnt_q - 2'h1;
                end
                default:
                    state_q <= BSCS_RESTART;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_cpu_reset <= 1'b1;
        else
            o_cpu_reset <= (state_q == BSCS_RESTART) || software_return_reset || (idle_rise && boot_control_reg_q == BSCS_CTRL_LOADER);
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_loader_flash_sel <= 1'b0;
        else
            o_loader_flash_sel <= loader_q;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_flash_update_en <= 1'b0;
        else
            o_flash_update_en <= loader_q | update_q;
    end

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            o_high_clock_select <= 1'b1;
        else
            o_high_clock_select <= code_security_byte_q[BSCS_SEC_HICLK]; // RULE14
    end

    bscs_access_gate u_gate
    (
        .i_read_lock_n          (code_security_byte_q[BSCS_SEC_LOCK] & sec_loaded_q),
        .i_table_read_inhibit_n (code_security_byte_q[BSCS_SEC_INHIBIT]),
        .i_flash_req            (i_flash_req & ~o_cpu_reset),
        .i_table_req            (i_table_req & ~o_cpu_reset & code_security_byte_q[BSCS_SEC_LOCK]),
        .i_exec_external        (i_exec_external),
        .i_target_internal      (i_target_internal),
        .o_flash_grant          (flash_grant_c),
        .o_table_grant          (table_grant_c)
    );

    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_flash_grant <= 1'b0;
            o_table_grant <= 1'b0;
        end
        else
        begin
            o_flash_grant <= flash_grant_c; // RULE8
            o_table_grant <= table_grant_c; // RULE9
        end
    end

    logic unused_ok;
    assign unused_ok = &{i_hsize, 1'b0};
endmodule : bscs_top

// ===== bscs_checker.sv
// checker of boot selection and code security outputs
`timescale 1ns/1ps
module bscs_checker
    import bscs_pkg::*;
(
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    // requests, straps and image
    input  wire logic       i_table_req,
    input  wire logic       i_exec_external,
    input  wire logic       i_target_internal,
    input  wire logic       i_reboot_pin_a,
    input  wire logic       i_reboot_pin_b,
    input  wire logic       i_reboot_pin_c,
    input  wire logic [7:0] i_nv_security,
    // watched outputs
    input  wire logic       o_loader_flash_sel,
    input  wire logic       o_cpu_reset,
    input  wire logic       o_flash_update_en,
    input  wire logic       o_flash_grant,
    input  wire logic       o_table_grant,
    input  wire logic       o_high_clock_select
);
    logic boot_q;
    logic strap_hit;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    assign strap_hit = (!i_nv_security[BSCS_SEC_PAIR] && !i_reboot_pin_a && !i_reboot_pin_b)
                    || (!i_nv_security[BSCS_SEC_SINGLE] && !i_reboot_pin_c);
    // only the first restart after reset release is a strap boot
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            boot_q <= 1'b1;
        else if ($fell(o_cpu_reset))
            boot_q <= 1'b0;
    end
    a_loader_with_restart:
        assert property ($rose(o_loader_flash_sel) |-> o_cpu_reset) else $error("loader switch without restart");
    a_restart_holds:
        assert property ($rose(o_cpu_reset) |-> o_cpu_reset[*4]) else $error("restart pulse too short");
    a_update_stays_app:
        assert property ($rose(o_flash_update_en) && !o_loader_flash_sel |-> !o_cpu_reset ##1 !o_loader_flash_sel)
        else $error("update mode left application area");
    a_lock_refuses:
        assert property (!i_nv_security[0] |-> !o_flash_grant && !o_table_grant) else $error("grant while locked");
    a_external_table:
        assert property (i_table_req && i_exec_external && i_target_internal && !i_nv_security[1]
            |=> !o_table_grant) else $error("external table read reached internal code");
    a_internal_table:
        assert property (i_table_req && !i_exec_external && i_nv_security[0] && !o_cpu_reset
            |=> o_table_grant) else $error("internal table read refused");
    a_free_table:
        assert property (i_table_req && i_nv_security[1:0] == 2'h3 && !o_cpu_reset |=> o_table_grant)
        else $error("unrestricted table read refused");
    a_strap_boot:
        assert property (boot_q && $fell(o_cpu_reset) |-> o_loader_flash_sel == strap_hit)
        else $error("boot area does not match straps");
    a_clock_bit:
        assert property (!o_cpu_reset |-> o_high_clock_select == i_nv_security[BSCS_SEC_HICLK])
        else $error("clock select differs from latched image");
    c_loader: cover property ($rose(o_loader_flash_sel));
    c_update: cover property ($rose(o_flash_update_en));
    c_inhibit: cover property (i_table_req && i_exec_external && i_target_internal && !i_nv_security[1]);
endmodule : bscs_checker

bind bscs_top bscs_checker u_bscs_checker (.i_clock, .i_rstn, .i_table_req, .i_exec_external,
    .i_target_internal, .i_reboot_pin_a, .i_reboot_pin_b, .i_reboot_pin_c, .i_nv_security,
    .o_loader_flash_sel, .o_cpu_reset, .o_flash_update_en, .o_flash_grant, .o_table_grant,
    .o_high_clock_select);

// ===== bscs_writer_model.sv
// model of the flash writer image and the reboot strap pins
`timescale 1ns/1ps
module bscs_writer_model #(
    parameter int CLK_MHZ = 40
) (
    // image and strap setup
    input  wire logic [7:0] i_image,
    input  wire logic [2:0] i_strap,
    input  wire logic       i_hold,
    // far side pins
    output logic            o_pin_a,
    output logic            o_pin_b,
    output logic            o_pin_c,
    output logic [7:0]      o_nv_security
);
    // one procedure hands over image bits 6:0 plus the clock bit set from CLK_MHZ > 24, both areas at once
    assign o_nv_security = {CLK_MHZ > 24, i_image[6:0]};
    // released straps float to the pull-up level
    assign o_pin_a = i_hold ? i_strap[0] : 1'b1;
    assign o_pin_b = i_hold ? i_strap[1] : 1'b1;
    assign o_pin_c = i_hold ? i_strap[2] : 1'b1;
endmodule : bscs_writer_model

// ===== bscs_top_test.sv
// self-checking bench for boot selection and code security
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module bscs_top_test
    import bscs_pkg::*;
;
    localparam int W_RDY = 0;
    localparam int W_RST = 1;
    localparam int W_UPD = 2;
    logic        clk, rstn, sel, wr, rd_q, idle, freq, treq, ext, tint, hold;
    logic        rdy, resp, ldr, crst, upd, fg, tg, hic, pa, pb, pc;
    logic [1:0]  trans;
    logic [2:0]  strap, mon;
    logic [7:0]  image, nv;
    logic [31:0] addr, wdata, rdata;
    logic [31:0] exp_q[$];
    logic [7:0]  cfg_im[6] = '{8'hff, 8'hff, 8'hef, 8'hdf, 8'hfd, 8'hfe};
    logic [2:0]  cfg_st[6] = '{3'h7, 3'h4, 3'h4, 3'h3, 3'h7, 3'h7};
    logic        cfg_ld[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    int          n_mismatch, n_tests, seed, i, k;
    assign mon = {upd, crst, rdy};
    bscs_top u_bscs_top (
        .i_clock(clk), .i_rstn(rstn), .i_hsel(sel), .i_haddr(addr), .i_htrans(trans),
        .i_hwrite(wr), .i_hsize(3'h2), .i_hwdata(wdata), .i_hready(rdy), .o_hrdata(rdata),
        .o_hreadyout(rdy), .o_hresp(resp), .i_cpu_idle(idle), .i_flash_req(freq),
        .i_table_req(treq), .i_exec_external(ext), .i_target_internal(tint),
        .i_reboot_pin_a(pa), .i_reboot_pin_b(pb), .i_reboot_pin_c(pc), .i_nv_security(nv),
        .o_loader_flash_sel(ldr), .o_cpu_reset(crst), .o_flash_update_en(upd),
        .o_flash_grant(fg), .o_table_grant(tg), .o_high_clock_select(hic));
    bscs_writer_model u_bscs_writer_model (.i_image(image), .i_strap(strap), .i_hold(hold),
        .o_pin_a(pa), .o_pin_b(pb), .o_pin_c(pc), .o_nv_security(nv));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // bounded wait on a watched output
    task automatic wait_for(input int w, input logic v);
        for (k = 0; k < 60; k++)
        begin
            @(posedge clk);
            if (mon[w] === v)
                return;
        end
        n_mismatch++;
        test_done();
    endtask : wait_for
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        sel <= 1'b1;
        trans <= BSCS_HTRANS_NONSEQ;
        addr <= a;
        wr <= w;
        wait_for(W_RDY, 1'b1);
        sel <= 1'b0;
        trans <= 2'h0;
        wdata <= d;
        rd_q <= !w;
        wait_for(W_RDY, 1'b1);
        rd_q <= 1'b0;
    endtask : bus
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    // image and straps only change while reset is held
    task automatic boot(input logic [7:0] im, input logic [2:0] st);
        @(posedge clk);
        rstn <= 1'b0;
        image <= im;
        strap <= st;
        hold <= 1'b1;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        wait_for(W_RST, 1'b0);
        hold <= 1'b0;
    endtask : boot
    task automatic grants(input logic [7:0] im);
        repeat (24)
        begin
            @(posedge clk);
            {freq, treq, ext, tint} <= 4'($random(seed));
            @(posedge clk);
            #1;
            `CHK(fg, freq & im[0])
            `CHK(tg, treq & im[0] & (im[1] | ~ext | ~tint))
        end
        {freq, treq, ext, tint} <= 4'h0;
    endtask : grants
    task automatic idle_cmd(input logic [7:0] c, input int w);
        bus(BSCS_OFF_CTRL, 1'b1, {24'h0, c});
        @(posedge clk);
        idle <= 1'b1;
        wait_for(w, 1'b1);
        idle <= 1'b0;
    endtask : idle_cmd
    always @(posedge clk)
        if (rd_q === 1'b1)
        begin
            `CHK(rdata, exp_q.pop_front())
            `CHK(resp, 1'b0)
        end
    initial
    begin
        {rstn, sel, wr, rd_q, idle, freq, treq, ext, tint} = 9'h0;
        {trans, addr, wdata, hold, image, strap} = {2'h0, 64'h0, 1'b1, 8'hff, 3'h7};
        {n_mismatch, n_tests, seed} = {32'd0, 32'd0, 32'd86332};
        for (i = 0; i < 6; i++)
        begin
            boot(cfg_im[i], cfg_st[i]);
            `CHK(ldr, cfg_ld[i])
            `CHK(hic, 1'b1)
            rd(BSCS_OFF_SECURITY, cfg_im[i][0] ? {24'h0, cfg_im[i]} : 32'h0);
            grants(cfg_im[i]);
        end
        boot(8'hff, 3'h7);
        rd(BSCS_OFF_CTRL, 32'h0);
        bus(BSCS_OFF_DEVICE_ID, 1'b1, 32'h0);
        rd(BSCS_OFF_DEVICE_ID, {24'h0, BSCS_DEVICE_ID});
        rd(BSCS_OFF_MAKER_ID, {24'h0, BSCS_MAKER_ID});
        rd(32'h0000_0024, 32'h0);
        bus(BSCS_OFF_SEC_PROG, 1'b1, 32'h0000_00ef);
        bus(BSCS_OFF_SEC_PROG, 1'b1, 32'h0000_00ff);
        rd(BSCS_OFF_SECURITY, 32'h0000_00ef);
        bus(BSCS_OFF_PROG_MODE, 1'b1, 32'h1);
        rd(BSCS_OFF_SECURITY, 32'h0);
        rd(BSCS_OFF_MAKER_ID, 32'h0);
        bus(BSCS_OFF_SEC_PROG, 1'b1, 32'h0000_00fe);
        bus(BSCS_OFF_PROG_MODE, 1'b1, 32'h0);
        rd(BSCS_OFF_SECURITY, 32'h0000_00ef);
        bus(BSCS_OFF_ERASE, 1'b1, BSCS_ERASE_KEY);
        rd(BSCS_OFF_SECURITY, {24'h0, BSCS_SEC_RESET});
        idle_cmd(BSCS_CTRL_LOADER, W_RST);
        wait_for(W_RST, 1'b0);
        `CHK(ldr, 1'b1)
        // bit 7 is the software return reset
        bus(BSCS_OFF_CTRL, 1'b1, 32'h0000_0080);
        wait_for(W_RST, 1'b1);
        wait_for(W_RST, 1'b0);
        `CHK(ldr, 1'b0)
        idle_cmd(BSCS_CTRL_UPDATE, W_UPD);
        `CHK(ldr, 1'b0)
        `CHK(crst, 1'b0)
        test_done();
    end
endmodule : bscs_top_test
